// File: rtl/bcp_regs.vh
`ifndef BCP_REGS_VH
`define BCP_REGS_VH

// register byte offsets
`define BCP_OFS_CTRL      8'h00
`define BCP_OFS_MODULO    8'h04
`define BCP_OFS_CH0_SC    8'h08
`define BCP_OFS_CH0_VAL   8'h0C
`define BCP_OFS_CH1_SC    8'h10
`define BCP_OFS_CH1_VAL   8'h14
`define BCP_OFS_COUNT     8'h18
`define BCP_OFS_STATUS    8'h1C

// control register fields
`define BCP_CTRL_PS_LSB   0
`define BCP_CTRL_PS_MSB   2
`define BCP_CTRL_RUN      4
`define BCP_CTRL_RST_CNT  5

// channel status/control fields
`define BCP_SC_ELSA       2
`define BCP_SC_ELSB       3
`define BCP_SC_TOV        0
`define BCP_SC_MSA        4
`define BCP_SC_BUF        5
`define BCP_SC_FLAG       7

// status fields
`define BCP_ST_ACTIVE     0
`define BCP_ST_PENDING    1
`define BCP_ST_OVF        2

// reset values
`define BCP_RST_MODULO    16'hFFFF
`define BCP_RST_CTRL      8'h00
`define BCP_RST_SC        8'h00
`define BCP_RST_VAL       16'h0000

// bus answers
`define BCP_RESP_OKAY     2'h0
`define BCP_RESP_SLVERR   2'h2

`endif

// File: rtl/bcp_prescaler.v
`timescale 1ns/10ps
module bcp_prescaler (
    input  wire       core_clk,
    input  wire       reset,
    input  wire       run,
    input  wire [2:0] sel,
    output reg        tick
);
    reg  [6:0] div;
    wire [6:0] mask;

    // divide by 2**sel; sel 0 gives a tick every bus clock
    assign mask = (7'h01 << sel) - 7'h01;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div  <= 7'h00;
            tick <= 1'b0;
        end else if (!run) begin
            div  <= 7'h00;
            tick <= 1'b0;
        end else begin
            div  <= ((div & mask) == mask) ? 7'h00 : div + 7'h01;
            tick <= ((div & mask) == mask);
        end
    end
endmodule

// File: rtl/bcp_timer.v
// Operation
// - channels 0 and 1 join into one buffered compare driving pin 0
// - buffered select bit in channel 0 control links the pair
// - channel 0 compare value governs pin 0 first after entry
// - write to channel 1 value hands control over at next overflow
// - at each overflow the most recently written set becomes active
// - in buffered mode channel 0 control rules; channel 1 control ignored
// - buffered mode releases pin 1 for general purpose use
// - pwm comes from toggle on overflow plus output compare
// - pin toggles at modulo value; period is overflow interval
// - pulse width is overflow to compare match time
// - 8-bit modulo gives 256 pwm increments
// - modulo 00FF, prescale 000 gives 256 bus clock period
`timescale 1ns/10ps
`include "bcp_regs.vh"
module bcp_timer (
    input  wire        core_clk,
    input  wire        reset,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         compare_out_pin0,
    output reg         compare_out_pin1,
    output wire        pin1_timer_owned
);
    reg  [7:0]  ctrl;
    reg  [15:0] modulo;
    reg  [7:0]  ch0_status_control;
    reg  [7:0]  ch1_status_control;
    reg  [15:0] ch0_val;
    reg  [15:0] ch1_val;
    reg  [15:0] count;
    reg         active_ch;
    reg         next_src;
    reg         pending;
    reg         ovf_seen;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        tick;
    wire        ovf;
    wire        buffered_mode_select;
    wire        do_write;
    wire        wr_ch0_val;
    wire        wr_ch1_val;
    wire        wr_ok;
    wire [15:0] act_val;
    wire        match0;
    wire        match1;
    wire [7:0]  sc_a;

    assign buffered_mode_select = ch0_status_control[`BCP_SC_BUF];
    assign pin1_timer_owned     = ~buffered_mode_select;

    bcp_prescaler bcp_prescaler_i (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (ctrl[`BCP_CTRL_RUN]),
        .sel      (ctrl[`BCP_CTRL_PS_MSB:`BCP_CTRL_PS_LSB]),
        .tick     (tick)
    );

    // overflow is the tick on which the counter sits at modulo
    assign ovf = tick && (count == modulo);

    // write-1 counter reset beats a tick in the same cycle
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= 16'h0000;
        end else if (do_write && aw_addr == `BCP_OFS_CTRL &&
                     w_strb[0] && w_data[`BCP_CTRL_RST_CNT]) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= ovf ? 16'h0000 : count + 16'h0001;
        end
    end

    // write channel: both address and data held until the pair is complete
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    // unmapped or unaligned writes answer an error and change nothing
    assign wr_ok         = (aw_addr[1:0] == 2'h0) &&
                           (aw_addr <= `BCP_OFS_STATUS);
    assign wr_ch0_val    = do_write && aw_addr == `BCP_OFS_CH0_VAL;
    assign wr_ch1_val    = do_write && aw_addr == `BCP_OFS_CH1_VAL;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BCP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `BCP_RESP_OKAY : `BCP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file; compare events set a channel flag after any write,
    // so a set beats a software clear in the same cycle
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl               <= `BCP_RST_CTRL;
            modulo             <= `BCP_RST_MODULO;
            ch0_status_control <= `BCP_RST_SC;
            ch1_status_control <= `BCP_RST_SC;
            ch0_val            <= `BCP_RST_VAL;
            ch1_val            <= `BCP_RST_VAL;
        end else begin
            if (do_write) begin
                case (aw_addr)
                    `BCP_OFS_CTRL: begin
                        if (w_strb[0])
                            ctrl <= {w_data[7:6], 1'b0, w_data[4:0]};
                    end
                    `BCP_OFS_MODULO: begin
                        if (w_strb[0]) modulo[7:0]  <= w_data[7:0];
                        if (w_strb[1]) modulo[15:8] <= w_data[15:8];
                    end
                    `BCP_OFS_CH0_SC: begin
                        if (w_strb[0]) begin
                            ch0_status_control[6:0] <= w_data[6:0];
                            if (!w_data[`BCP_SC_FLAG])
                                ch0_status_control[`BCP_SC_FLAG] <= 1'b0;
                        end
                    end
                    `BCP_OFS_CH1_SC: begin
                        if (w_strb[0]) begin
                            ch1_status_control[6:0] <= w_data[6:0];
                            if (!w_data[`BCP_SC_FLAG])
                                ch1_status_control[`BCP_SC_FLAG] <= 1'b0;
                        end
                    end
                    `BCP_OFS_CH0_VAL: begin
                        if (w_strb[0]) ch0_val[7:0]  <= w_data[7:0];
                        if (w_strb[1]) ch0_val[15:8] <= w_data[15:8];
                    end
                    `BCP_OFS_CH1_VAL: begin
                        if (w_strb[0]) ch1_val[7:0]  <= w_data[7:0];
                        if (w_strb[1]) ch1_val[15:8] <= w_data[15:8];
                    end
                    default: begin
                    end
                endcase
            end
            if (match0)
                ch0_status_control[`BCP_SC_FLAG] <= 1'b1;
            if (match1 && !buffered_mode_select)
                ch1_status_control[`BCP_SC_FLAG] <= 1'b1;
        end
    end

    // buffered source selection; a write to the active set is used at once
    // since act_val reads the live register, hence unbuffered behaviour
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            active_ch <= 1'b0;
            next_src  <= 1'b0;
            pending   <= 1'b0;
        end else if (!buffered_mode_select) begin
            active_ch <= 1'b0;
            next_src  <= 1'b0;
            pending   <= 1'b0;
        end else begin
            if (wr_ch1_val) begin
                next_src <= 1'b1;
                pending  <= 1'b1;
            end else if (wr_ch0_val) begin
                next_src <= 1'b0;
                pending  <= 1'b1;
            end
            // a value write in the overflow cycle wins over the queued source
            if (ovf && (pending || wr_ch0_val || wr_ch1_val)) begin
                active_ch <= wr_ch1_val ? 1'b1 :
                             wr_ch0_val ? 1'b0 : next_src;
                pending   <= 1'b0;
            end
        end
    end

    assign act_val = (buffered_mode_select && active_ch) ? ch1_val
                                                         : ch0_val;
    assign match0  = tick && (count == act_val);
    // pin 1 compares its own value; unused while the pair is linked
    assign match1  = tick && (count == ch1_val);
    // channel 0 control governs the pair; channel 1 control ignored
    assign sc_a    = ch0_status_control;

    // pin action: compare level per select bits, overflow toggle, pwm
    function [0:0] pin_next;
        input       cur;
        input [7:0] sc;
        input       m;
        input       o;
        reg         v;
        begin
            v = cur;
            if (m) begin
                case (sc[`BCP_SC_ELSB:`BCP_SC_ELSA])
                    2'b01:   v = ~cur;
                    2'b10:   v = 1'b0; // high pulse, clear on compare
                    2'b11:   v = 1'b1; // low pulse, set on compare
                    default: v = cur;
                endcase
            end
            if (o && sc[`BCP_SC_TOV]) v = ~v;
            pin_next = v;
        end
    endfunction

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            compare_out_pin0 <= 1'b0;
            compare_out_pin1 <= 1'b0;
            ovf_seen         <= 1'b0;
        end else begin
            compare_out_pin0 <= pin_next(compare_out_pin0, sc_a,
                                         match0, ovf);
            if (buffered_mode_select)
                compare_out_pin1 <= 1'b0;
            else
                compare_out_pin1 <= pin_next(compare_out_pin1,
                                             ch1_status_control,
                                             match1, ovf);
            // sticky overflow flag: a new overflow beats a clear
            if (ovf)
                ovf_seen <= 1'b1;
            else if (do_write && aw_addr == `BCP_OFS_STATUS && w_strb[0] &&
                     w_data[`BCP_ST_OVF])
                ovf_seen <= 1'b0;
        end
    end

    // read channel
    // data come from a register the cycle after the address is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `BCP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `BCP_RESP_OKAY;
            case (s_axi_araddr)
                `BCP_OFS_CTRL:    s_axi_rdata <= {24'h000000, ctrl};
                `BCP_OFS_MODULO:  s_axi_rdata <= {16'h0000, modulo};
                `BCP_OFS_CH0_SC:  s_axi_rdata <= {24'h000000,
                                                  ch0_status_control};
                `BCP_OFS_CH1_SC:  s_axi_rdata <= {24'h000000,
                                                  ch1_status_control};
                `BCP_OFS_CH0_VAL: s_axi_rdata <= {16'h0000, ch0_val};
                `BCP_OFS_CH1_VAL: s_axi_rdata <= {16'h0000, ch1_val};
                `BCP_OFS_COUNT:   s_axi_rdata <= {16'h0000, count};
                `BCP_OFS_STATUS:  s_axi_rdata <= {29'h0, ovf_seen,
                                                  pending, active_ch};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `BCP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: tb/bcp_timer_sva.sv
`timescale 1ns/10ps
`include "bcp_regs.vh"
module bcp_timer_sva (
    input wire        core_clk,
    input wire        reset,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        compare_out_pin1,
    input wire        pin1_timer_owned
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
        else $error("no write response after address and data");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    bresp_end_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    wr_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read data after address");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    rd_unmap_a: assert property (rd_taken ##0 (s_axi_araddr > 8'h1C)
        |=> s_axi_rresp == `BCP_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    pin1_free_a: assert property (
        !pin1_timer_owned |=> !compare_out_pin1)
        else $error("pin 1 driven while released");
endmodule

bind bcp_timer bcp_timer_sva bcp_timer_sva_i (.core_clk, .reset,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .compare_out_pin1, .pin1_timer_owned);

// File: tb/bcp_timer_tb.sv
`timescale 1ns/10ps
`include "bcp_regs.vh"
module bcp_timer_tb;
    logic        core_clk = 0;
    logic        reset = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         compare_out_pin0, compare_out_pin1, pin1_timer_owned;
    int          n_fail = 0, tests_run = 0;
    int          w0, w1, p;
    int          mods[3] = '{255, 127, 255};
    int          pss[3] = '{0, 0, 1};
    logic [31:0] v;
    logic [1:0]  rsp;
    logic        ta, tw, dn;

    always #4 core_clk = ~core_clk;

    bcp_timer bcp_timer_i (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_out_pin0,
        .compare_out_pin1, .pin1_timer_owned);

    task results;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task tmo(input bit hit);
        if (hit) begin
            n_fail++;
            $display("ERROR t=%0t wait limit reached", $time);
            results;
        end
    endtask

    // every release happens on the rising edge the handshake is seen at
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            dn = 0;
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!dn && n < 200) begin
                @(negedge core_clk);
                n++;
                ta = s_axi_awready;
                tw = s_axi_wready;
                dn = s_axi_bvalid;
                rsp = s_axi_bresp;
                @(posedge core_clk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (dn) s_axi_bready <= 1'b0;
            end
            tmo(!dn);
        end
    endtask

    task rd(input logic [7:0] a);
        int n;
        begin
            n = 0;
            dn = 0;
            @(posedge core_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!dn && n < 200) begin
                @(negedge core_clk);
                n++;
                ta = s_axi_arready;
                dn = s_axi_rvalid;
                v = s_axi_rdata;
                rsp = s_axi_rresp;
                @(posedge core_clk);
                if (ta) s_axi_arvalid <= 1'b0;
                if (dn) s_axi_rready <= 1'b0;
            end
            tmo(!dn);
        end
    endtask

    task cnt(input logic lvl, output int c);
        c = 0;
        while (compare_out_pin0 === lvl && c < 2000) begin
            @(negedge core_clk);
            c++;
        end
        tmo(compare_out_pin0 === lvl);
    endtask

    // high time and period of the next whole pulse on pin 0
    task meas(output int hi, output int per);
        int c;
        begin
            @(negedge core_clk);
            cnt(1'b1, c);
            cnt(1'b0, c);
            cnt(1'b1, hi);
            cnt(1'b0, c);
            per = hi + c;
        end
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(`BCP_OFS_MODULO);
        chk(v, 32'h0000FFFF);
        rd(8'h20);
        chk(32'(rsp), 32'(`BCP_RESP_SLVERR));
        chk(v, 32'h0);
        wr(8'h20, 32'h0);
        chk(32'(rsp), 32'(`BCP_RESP_SLVERR));
        chk(32'(pin1_timer_owned), 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(`BCP_OFS_CTRL, 32'h0);
            wr(`BCP_OFS_MODULO, 32'(mods[i]));
            wr(`BCP_OFS_CH0_SC, 32'h09);
            wr(`BCP_OFS_CH0_VAL, 32'h40);
            wr(`BCP_OFS_CTRL, 32'h30 | 32'(pss[i]));
            meas(w0, p);
            chk(32'(p), 32'((mods[i]+1) << pss[i]));
            chk(32'(w0), 32'(65 << pss[i]));
            wr(`BCP_OFS_CH0_VAL, 32'h60);
            meas(w1, p);
            chk(32'(w1 - w0), 32'(32 << pss[i]));
        end
        // buffered pair: ch0 first, then the most recently written set
        wr(`BCP_OFS_CTRL, 32'h0);
        wr(`BCP_OFS_MODULO, 32'h00FF);
        wr(`BCP_OFS_CH0_VAL, 32'h20);
        wr(`BCP_OFS_CH0_SC, 32'h29);
        chk(32'(pin1_timer_owned), 32'h0);
        wr(`BCP_OFS_CTRL, 32'h30);
        meas(w0, p);
        chk(32'(p), 32'h100);
        chk(32'(w0), 32'h21);
        wr(`BCP_OFS_CH1_VAL, 32'h60);
        meas(w1, p);
        chk(32'(w1 - w0), 32'h40);
        rd(`BCP_OFS_STATUS);
        chk(32'(v[`BCP_ST_ACTIVE]), 32'h1);
        wr(`BCP_OFS_CH1_SC, 32'h0C);
        wr(`BCP_OFS_CH0_VAL, 32'h40);
        meas(w1, p);
        chk(32'(w1 - w0), 32'h20);
        chk(32'(compare_out_pin1), 32'h0);
        rd(`BCP_OFS_STATUS);
        chk(32'(v[`BCP_ST_OVF]), 32'h1);
        rd(`BCP_OFS_CH0_SC);
        chk(v, 32'hA9);
        // active-low pulse, then toggle on compare alone
        wr(`BCP_OFS_CH0_SC, 32'h0D);
        chk(32'(pin1_timer_owned), 32'h1);
        meas(w1, p);
        chk(32'(p - w1), 32'h41);
        wr(`BCP_OFS_CH0_SC, 32'h04);
        meas(w1, p);
        chk(32'(p), 32'h200);
        // stopped timer: software clears the sticky flags, counter resets
        wr(`BCP_OFS_CTRL, 32'h0);
        wr(`BCP_OFS_STATUS, 32'h4);
        rd(`BCP_OFS_STATUS);
        chk(32'(v[`BCP_ST_OVF]), 32'h0);
        rd(`BCP_OFS_CH0_SC);
        chk(v, 32'h84);
        wr(`BCP_OFS_CH0_SC, 32'h04);
        rd(`BCP_OFS_CH0_SC);
        chk(v, 32'h04);
        wr(`BCP_OFS_CTRL, 32'h20);
        rd(`BCP_OFS_COUNT);
        chk(v, 32'h0);
        rd(`BCP_OFS_CTRL);
        chk(v, 32'h0);
        results;
    end
endmodule
